// ===== design/usbepr_pkg.sv
// package of constants and carrier types for the usb endpoint fifo and interrupt register block
// assumes an 8-bit special-function register port from the core and a same-clock usb serial engine
// What this block does, and what firmware must do (RULE_02, RULE_14)
// RULE_01: writing one then zero empties that FIFO
// RULE_02: firmware pulses each FIFO reset before use
// RULE_03: unused upper bits read zero, never written
// RULE_04: per-endpoint enable bits pass or block interrupts
// RULE_05: flag sets when any endpoint source active
// RULE_06: sources are the five endpoint status bits
// RULE_07: irq raised only for enabled set flags
// RULE_08: flag clears itself; writes to flags ignored
// RULE_09: data port pushes or pops selected FIFO
// RULE_10: seven-bit received byte count, bit seven zero
// RULE_11: low frame number byte, read-only, resets zero
// RULE_12: upper three frame bits in next register
// RULE_13: corrupted start-of-frame leaves frame number unchanged
// RULE_14: firmware clears transmit-complete before marking ready
// RULE_15: each data access advances FIFO pointer one
// RULE_16: data port and count follow selected endpoint
package usbepr_pkg;

  // ===========================================================
  // register offsets in the special-function space
  localparam logic [7:0] ADDR_FRAME_NUM_LOW = 8'hBA;
  localparam logic [7:0] ADDR_FRAME_NUM_HIGH = 8'hBB;
  localparam logic [7:0] ADDR_EP_IRQ_ENABLE = 8'hC2;
  localparam logic [7:0] ADDR_EP_FIFO_DATA = 8'hCF;
  localparam logic [7:0] ADDR_EP_FIFO_RESET = 8'hD5;
  localparam logic [7:0] ADDR_EP_BYTE_COUNT = 8'hE2;
  localparam logic [7:0] ADDR_EP_IRQ_FLAGS = 8'hF8;

  // ===========================================================
  // sizes, field positions and reset values
  localparam int NUM_EP = 3;
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_PTR_W = 6;
  localparam int BYTE_CNT_W = 7;
  localparam int FRAME_W = 11;
  localparam int FRAME_HIGH_W = 3;
  localparam int FRAME_HIGH_CRCERR_BIT = 4;
  localparam int FRAME_HIGH_CRCOK_BIT = 5;
  localparam logic [2:0] EP_BITS_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 11'h000;

  // ===========================================================
  // carrier types
  // one endpoint's status bits (interrupt sources)
  typedef struct packed {
    logic stall_sent_or_crc_bad;
    logic setup_received;
    logic out_bank1_full;
    logic out_bank0_full;
    logic in_sent_done;
  } usbepr_ep_status_t;

  // core access on the register port
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } usbepr_sfr_req_t;

  // start-of-frame report from the serial engine
  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic [FRAME_W-1:0] frame;
  } usbepr_sof_t;

  // byte traffic between the serial engine and the FIFOs
  typedef struct packed {
    logic [1:0] ep;
    logic pkt_start;
    logic rx_push;
    logic [7:0] rx_byte;
    logic tx_pop;
  } usbepr_link_t;

endpackage

// ===== design/usbepr_fifo.sv
// one endpoint's byte FIFO: circular buffer with one push port and one pop port
// assumes a synchronous clear held by the owner and no push when full, no pop when empty
`timescale 1ns/1ps
module usbepr_fifo (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control
  input wire logic clear,
  // fill side
  input wire logic push,
  input wire logic [7:0] push_byte,
  // drain side
  input wire logic pop,
  output logic [7:0] head_byte,
  // state
  output logic empty,
  output logic full
);

  // ===========================================================
  // storage and pointers
  logic [7:0] mem_r [usbepr_pkg::FIFO_DEPTH]; // byte storage, not reset
  logic [usbepr_pkg::FIFO_PTR_W-1:0] wr_ptr_r; // next slot to fill
  logic [usbepr_pkg::FIFO_PTR_W-1:0] rd_ptr_r; // oldest byte
  logic [usbepr_pkg::FIFO_PTR_W:0] count_r; // bytes held, 0..depth
  logic do_push;
  logic do_pop;

  // refuse overflow and underflow so pointers never pass each other
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign empty = (count_r == '0);
  assign full = (count_r == (usbepr_pkg::FIFO_PTR_W+1)'(usbepr_pkg::FIFO_DEPTH));
  assign head_byte = mem_r[rd_ptr_r];

  // storage write, no reset needed for data
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= push_byte;
    end
  end

  // pointers advance one byte per access; clear empties the buffer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (clear) begin
      wr_ptr_r <= '0; // RULE_01
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1; // RULE_15
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1; // RULE_15
      end
      count_r <= count_r + (usbepr_pkg::FIFO_PTR_W+1)'(do_push) - (usbepr_pkg::FIFO_PTR_W+1)'(do_pop);
    end
  end

endmodule

// ===== design/usbepr_regs.sv
// endpoint FIFO, interrupt and frame-number registers of a three-endpoint usb device controller
// assumes the core's register port and the serial engine both run on clk_sys; the endpoint
// selection and status bits are kept elsewhere and arrive here as plain inputs
`timescale 1ns/1ps
module usbepr_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // core register port
  input wire usbepr_pkg::usbepr_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // endpoint selection and status from elsewhere
  input wire logic [1:0] selected_endpoint,
  input wire usbepr_pkg::usbepr_ep_status_t [2:0] endpoint_status,
  // serial engine side
  input wire usbepr_pkg::usbepr_link_t link,
  input wire usbepr_pkg::usbepr_sof_t sof,
  output logic [7:0] tx_byte,
  output logic [2:0] fifo_empty,
  output logic [2:0] fifo_full,
  // interrupt request to the core
  output logic usb_ep_irq
);

  // ===========================================================
  // registers
  logic [2:0] fifo_clear_r; // endpoint FIFO reset bits
  logic [2:0] irq_en_r; // endpoint interrupt enables
  logic [2:0] irq_flag_r; // endpoint interrupt flags
  logic [7:0] rdata_r; // read data holding register
  logic [usbepr_pkg::FRAME_W-1:0] frame_num_r; // last good frame number
  logic sof_crc_ok_r; // last start-of-frame was good
  logic sof_crc_err_r; // last start-of-frame was corrupted
  logic [usbepr_pkg::BYTE_CNT_W-1:0] rx_byte_count_r [usbepr_pkg::NUM_EP]; // bytes after data PID
  logic usb_ep_irq_r; // registered request

  // ===========================================================
  // decode
  logic wr_fifo_reset;
  logic wr_irq_en;
  logic acc_data_wr;
  logic acc_data_rd;
  logic [2:0] ep_any_src; // any source active per endpoint
  logic [2:0] cpu_push;
  logic [2:0] cpu_pop;
  logic [2:0] link_push;
  logic [2:0] link_pop;
  logic [7:0] head_byte [usbepr_pkg::NUM_EP];
  logic [2:0] sel_onehot;
  logic [2:0] link_onehot;

  assign wr_fifo_reset = sfr_req.wr && (sfr_req.addr == usbepr_pkg::ADDR_EP_FIFO_RESET);
  assign wr_irq_en = sfr_req.wr && (sfr_req.addr == usbepr_pkg::ADDR_EP_IRQ_ENABLE);
  assign acc_data_wr = sfr_req.wr && (sfr_req.addr == usbepr_pkg::ADDR_EP_FIFO_DATA);
  assign acc_data_rd = sfr_req.rd && (sfr_req.addr == usbepr_pkg::ADDR_EP_FIFO_DATA);

  // endpoint numbers to one-hot; codes above 2 select nothing
  always_comb begin
    sel_onehot = 3'h0;
    link_onehot = 3'h0;
    if (selected_endpoint < 2'h3) begin
      sel_onehot[selected_endpoint] = 1'b1; // RULE_16
    end
    if (link.ep < 2'h3) begin
      link_onehot[link.ep] = 1'b1;
    end
  end

  // ===========================================================
  // per-endpoint FIFOs
  // the core's access to the selected endpoint takes precedence over the serial engine in the
  // same cycle; the engine is expected not to touch the endpoint that firmware is servicing
  assign cpu_push = acc_data_wr ? sel_onehot : 3'h0; // RULE_09
  assign cpu_pop = acc_data_rd ? sel_onehot : 3'h0; // RULE_09
  assign link_push = link.rx_push ? link_onehot : 3'h0;
  assign link_pop = link.tx_pop ? link_onehot : 3'h0;

  for (genvar e = 0; e < usbepr_pkg::NUM_EP; e++) begin : g_ep
    usbepr_fifo u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clear(fifo_clear_r[e]),
      .push(cpu_push[e] || link_push[e]),
      .push_byte(cpu_push[e] ? sfr_req.wdata : link.rx_byte),
      .pop(cpu_pop[e] || (link_pop[e] && !cpu_push[e])),
      .head_byte(head_byte[e]),
      .empty(fifo_empty[e]),
      .full(fifo_full[e])
    );
    // any status bit of the endpoint counts as a source
    assign ep_any_src[e] = |endpoint_status[e]; // RULE_06
  end

  // ===========================================================
  // FIFO reset register: a bit held at one keeps its FIFO empty
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fifo_clear_r <= usbepr_pkg::EP_BITS_RESET;
    end else if (wr_fifo_reset) begin
      fifo_clear_r <= sfr_req.wdata[2:0]; // RULE_01
    end
  end

  // interrupt enable register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_r <= usbepr_pkg::EP_BITS_RESET;
    end else if (wr_irq_en) begin
      irq_en_r <= sfr_req.wdata[2:0]; // RULE_04
    end
  end

  // interrupt flags follow the sources; no write path exists, so core writes are ignored
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag_r <= usbepr_pkg::EP_BITS_RESET;
    end else begin
      irq_flag_r <= ep_any_src; // RULE_05 RULE_08
    end
  end

  // request only for a set flag whose endpoint is enabled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      usb_ep_irq_r <= 1'b0;
    end else begin
      usb_ep_irq_r <= |(irq_flag_r & irq_en_r); // RULE_04 RULE_07
    end
  end
  assign usb_ep_irq = usb_ep_irq_r;

  // ===========================================================
  // received byte counts: restart at a data PID, count each byte that follows
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < usbepr_pkg::NUM_EP; i++) begin
        rx_byte_count_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < usbepr_pkg::NUM_EP; i++) begin
        if (link_onehot[i] && link.pkt_start) begin
          rx_byte_count_r[i] <= '0; // RULE_10
        end else if (link_push[i] && !cpu_push[i]) begin
          rx_byte_count_r[i] <= rx_byte_count_r[i] + 1'b1; // RULE_10
        end
      end
    end
  end

  // ===========================================================
  // frame number: only an intact start-of-frame updates it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_num_r <= usbepr_pkg::FRAME_RESET;
    end else if (sof.valid && sof.crc_ok) begin
      frame_num_r <= sof.frame; // RULE_11 RULE_12 RULE_13
    end
  end

  // crc status of the latest start-of-frame, rewritten each time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sof_crc_ok_r <= 1'b0;
      sof_crc_err_r <= 1'b0;
    end else if (sof.valid) begin
      sof_crc_ok_r <= sof.crc_ok;
      sof_crc_err_r <= !sof.crc_ok;
    end
  end

  // ===========================================================
  // read data: captured on the read strobe, unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= usbepr_pkg::BYTE_RESET;
    end else if (sfr_req.rd) begin
      rdata_r <= usbepr_pkg::BYTE_RESET;
      unique case (sfr_req.addr)
        usbepr_pkg::ADDR_FRAME_NUM_LOW: begin
          rdata_r <= frame_num_r[7:0]; // RULE_11
        end
        usbepr_pkg::ADDR_FRAME_NUM_HIGH: begin
          rdata_r[usbepr_pkg::FRAME_HIGH_W-1:0] <= frame_num_r[usbepr_pkg::FRAME_W-1:8]; // RULE_12
          rdata_r[usbepr_pkg::FRAME_HIGH_CRCERR_BIT] <= sof_crc_err_r;
          rdata_r[usbepr_pkg::FRAME_HIGH_CRCOK_BIT] <= sof_crc_ok_r;
        end
        usbepr_pkg::ADDR_EP_IRQ_ENABLE: begin
          rdata_r[2:0] <= irq_en_r; // RULE_03
        end
        usbepr_pkg::ADDR_EP_FIFO_DATA: begin
          // the head byte is taken in the same cycle that pops it
          rdata_r <= (selected_endpoint < 2'h3) ? head_byte[selected_endpoint] : 8'h00; // RULE_09 RULE_16
        end
        usbepr_pkg::ADDR_EP_FIFO_RESET: begin
          rdata_r[2:0] <= fifo_clear_r; // RULE_03
        end
        usbepr_pkg::ADDR_EP_BYTE_COUNT: begin
          // bit 7 stays zero
          rdata_r[usbepr_pkg::BYTE_CNT_W-1:0] <=
            (selected_endpoint < 2'h3) ? rx_byte_count_r[selected_endpoint] : 7'h00; // RULE_10 RULE_16
        end
        usbepr_pkg::ADDR_EP_IRQ_FLAGS: begin
          rdata_r[2:0] <= irq_flag_r; // RULE_03
        end
        default: begin
          rdata_r <= usbepr_pkg::BYTE_RESET;
        end
      endcase
    end
  end
  assign sfr_rdata = rdata_r;

  // transmit byte for the serial engine: head of the endpoint it addresses, registered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_byte <= usbepr_pkg::BYTE_RESET;
    end else if (link.tx_pop && link.ep < 2'h3) begin
      tx_byte <= head_byte[link.ep];
    end
  end

endmodule

// ===== sim/usbepr_regs_properties.sv
// concurrent checks on the endpoint register block ports
// assumes it is bound to usbepr_regs and sees only its ports
`timescale 1ns/1ps
module usbepr_regs_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // core register port
  input wire usbepr_pkg::usbepr_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  // status, frame and fifo levels
  input wire usbepr_pkg::usbepr_ep_status_t [2:0] endpoint_status,
  input wire usbepr_pkg::usbepr_sof_t sof,
  input wire logic [2:0] fifo_empty,
  input wire logic usb_ep_irq
);
  // =====
  // helpers
  logic [2:0] any_src; // per endpoint: some source active
  logic [2:0] clr; // fifo clear bits being written
  logic [7:0] frame_lo; // low frame byte on the sof report
  logic [1:0] up_r; // edges since reset, saturates at 3
  assign any_src = {|endpoint_status[2], |endpoint_status[1], |endpoint_status[0]};
  assign clr = sfr_req.wdata[2:0];
  assign frame_lo = sof.frame[7:0];
  // keeps $past from looking back into reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // =====
  // sequences
  sequence rd_at(logic [7:0] a);
    sfr_req.rd && sfr_req.addr == a;
  endsequence
  sequence sof_good;
    sof.valid && sof.crc_ok;
  endsequence
  // =====
  // properties
  irq_cause_a: assert property (usb_ep_irq && up_r == 2'h3 |-> $past(any_src, 2) != 3'h0)
    else $error("irq raised with no source active");
  irq_drop_a: assert property ((any_src == 3'h0) [*2] |=> !usb_ep_irq)
    else $error("irq held after all sources cleared");
  flag_read_a: assert property (up_r == 2'h3 ##0 rd_at(8'hF8) |=> sfr_rdata == {5'h00, $past(any_src, 2)})
    else $error("flag register does not mirror sources");
  rsvd_zero_a: assert property (sfr_req.rd && sfr_req.addr inside {8'hC2, 8'hD5, 8'hF8} |=> sfr_rdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  count_msb_a: assert property (rd_at(8'hE2) |=> !sfr_rdata[7])
    else $error("byte count bit 7 set");
  frame_load_a: assert property (sof_good ##1 (!sof.valid ##0 rd_at(8'hBA)) |=> sfr_rdata == $past(frame_lo, 2))
    else $error("low frame byte not loaded");
  rdata_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  fifo_clear_a: assert property (sfr_req.wr && sfr_req.addr == 8'hD5 |=> ##1 (fifo_empty & $past(clr, 2)) == $past(clr, 2))
    else $error("fifo not empty while its clear bit is set");
endmodule
bind usbepr_regs usbepr_regs_properties i_usbepr_regs_properties (.clk_sys(clk_sys), .rst_b(rst_b),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .endpoint_status(endpoint_status), .sof(sof),
  .fifo_empty(fifo_empty), .usb_ep_irq(usb_ep_irq));

// ===== sim/usbepr_host_model.sv
// serial engine stand-in: packets, pops and start-of-frame reports
// assumes the bench calls one task at a time; drives on the falling edge
`timescale 1ns/1ps
module usbepr_host_model (
  // clock
  input wire logic clk_sys,
  // from the block
  input wire logic [7:0] tx_byte,
  // towards the block
  output usbepr_pkg::usbepr_link_t link,
  output usbepr_pkg::usbepr_sof_t sof
);
  int gap = 1; // idle cycles after each byte, raised to go slow
  initial begin
    link = '0;
    sof = '0;
  end
  // data pid then one push per byte; the byte line is inverted once released
  task automatic send_packet(input logic [1:0] ep, input logic [7:0] b[$]);
    @(negedge clk_sys);
    link.ep = ep;
    link.pkt_start = 1'b1;
    foreach (b[i]) begin
      @(negedge clk_sys);
      link.pkt_start = 1'b0;
      link.rx_push = 1'b1;
      link.rx_byte = b[i];
      @(negedge clk_sys);
      link.rx_push = 1'b0;
      link.rx_byte = ~b[i];
      repeat (gap - 1) @(negedge clk_sys);
    end
  endtask
  // one pop; the head byte shows a cycle later
  task automatic pop_byte(input logic [1:0] ep, output logic [7:0] got);
    @(negedge clk_sys);
    link.ep = ep;
    link.tx_pop = 1'b1;
    @(negedge clk_sys);
    link.tx_pop = 1'b0;
    got = tx_byte;
  endtask
  // one eleven-bit frame report, number inverted afterwards
  task automatic send_sof(input logic [10:0] f, input logic ok);
    @(negedge clk_sys);
    sof = {1'b1, ok, f};
    @(negedge clk_sys);
    sof = {1'b0, ~ok, ~f};
  endtask
endmodule

// ===== sim/usbepr_regs_tb.sv
// self-checking bench for the endpoint register block
// assumes the host model drives the link; status bits come from here
`timescale 1ns/1ps
module usbepr_regs_tb;
  // =====
  // signals and model state
  logic clk_sys;
  logic rst_b;
  usbepr_pkg::usbepr_sfr_req_t sfr_req;
  logic [7:0] sfr_rdata;
  logic [1:0] sel;
  usbepr_pkg::usbepr_ep_status_t [2:0] st;
  usbepr_pkg::usbepr_link_t link;
  usbepr_pkg::usbepr_sof_t sof;
  logic [7:0] tx_byte;
  logic [2:0] fifo_empty;
  logic [2:0] fifo_full;
  logic usb_ep_irq;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] q[$]; // bytes expected out of a fifo
  logic [7:0] d;
  logic [2:0] en; // model of the enable register
  logic [2:0] fl; // model of the flags
  logic [10:0] f;
  logic [7:0] ra[7] = '{8'hBA, 8'hBB, 8'hC2, 8'hD5, 8'hE2, 8'hF8, 8'h10};
  int cnt[3] = '{0, 0, 0}; // model of each endpoint's last received byte count
  usbepr_regs i_usbepr_regs (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .selected_endpoint(sel), .endpoint_status(st), .link(link), .sof(sof), .tx_byte(tx_byte),
    .fifo_empty(fifo_empty), .fifo_full(fifo_full), .usb_ep_irq(usb_ep_irq));
  usbepr_host_model i_usbepr_host_model (.clk_sys(clk_sys), .tx_byte(tx_byte), .link(link), .sof(sof));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // =====
  // tasks
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: expected %h, got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    sfr_req = '{a, 1'b1, 1'b0, v};
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
  endtask
  // read strobe for one cycle, data is there at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_req = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk_sys);
    sfr_req.rd = 1'b0;
    cmp(e, sfr_rdata);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // =====
  // tests
  initial begin
    sfr_req = '0;
    sel = 2'h0;
    st = '0;
    rst_b = 1'b0;
    void'($urandom(9462));
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00);
    $display("test reset values done");
    wr(8'hD5, 8'h07);
    rd(8'hD5, 8'h07);
    cmp(8'h07, {5'h00, fifo_empty});
    wr(8'hD5, 8'h00);
    $display("test fifo reset done");
    // received packets: count, then drain through the data port
    for (int e = 0; e < 3; e++) begin
      q.delete();
      repeat (2 + e * 3) q.push_back(8'($urandom));
      i_usbepr_host_model.gap = 1 + e;
      i_usbepr_host_model.send_packet(2'(e), q);
      cnt[e] = q.size();
      sel = 2'(e);
      rd(8'hE2, 8'(cnt[e]));
      sel = 2'((e + 1) % 3);
      rd(8'hE2, 8'(cnt[(e + 1) % 3]));
      sel = 2'(e);
      foreach (q[i]) rd(8'hCF, q[i]);
    end
    // a second packet must restart the count, not add to it
    q.delete();
    q.push_back(8'($urandom));
    i_usbepr_host_model.send_packet(2'h0, q);
    sel = 2'h0;
    rd(8'hE2, 8'h01);
    rd(8'hCF, q[0]);
    $display("test receive done");
    // core fills endpoint 1, host pops it
    sel = 2'h1;
    // firmware side: transmit-complete is cleared before the next IN fill
    st[1].in_sent_done = 1'b0;
    q.delete();
    repeat (5) q.push_back(8'($urandom));
    foreach (q[i]) wr(8'hCF, q[i]);
    foreach (q[i]) begin
      i_usbepr_host_model.pop_byte(2'h1, d);
      cmp(q[i], d);
    end
    sel = 2'h2;
    repeat (3) wr(8'hCF, 8'($urandom));
    cmp(8'h03, {5'h00, fifo_empty});
    // fill endpoint 2 to its 64-byte depth so the full level shows
    repeat (61) wr(8'hCF, 8'($urandom));
    cmp(8'h04, {5'h00, fifo_full});
    wr(8'hD5, 8'h04);
    wr(8'hD5, 8'h00);
    cmp(8'h07, {5'h00, fifo_empty});
    cmp(8'h00, {5'h00, fifo_full});
    $display("test transmit done");
    // every source on every endpoint, random enables and a second endpoint
    for (int k = 0; k < 15; k++) begin
      en = 3'($urandom);
      wr(8'hC2, {5'h00, en});
      st = '0;
      st[(k + 1) % 3] = 5'($urandom);
      st[k % 3] = 5'(1 << (k % 5));
      fl = {|st[2], |st[1], |st[0]};
      wr(8'hF8, 8'h07);
      rd(8'hC2, {5'h00, en});
      rd(8'hF8, {5'h00, fl});
      cmp({7'h00, |(fl & en)}, {7'h00, usb_ep_irq});
    end
    st = '0;
    repeat (3) @(negedge clk_sys);
    rd(8'hF8, 8'h00);
    cmp(8'h00, {7'h00, usb_ep_irq});
    $display("test interrupts done");
    f = 11'($urandom);
    fork
      i_usbepr_host_model.send_sof(f, 1'b1);
      begin
        @(negedge clk_sys);
        rd(8'hBA, f[7:0]);
      end
    join
    rd(8'hBB, {5'h04, f[10:8]});
    i_usbepr_host_model.send_sof(~f, 1'b0);
    rd(8'hBA, f[7:0]);
    rd(8'hBB, {5'h02, f[10:8]});
    $display("test frame number done");
    tally_and_finish();
  end
endmodule
